// >>> rtl/sps_sram_page_select.sv
// Purpose: sram page selection, page pointer registers, flags save/restore, scratch registers
// Assumes: cpu sequencer presents one access per cycle; register port is synchronous
// Notes: outputs are registered, so the sram sees the address one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module sps_sram_page_select #(
  parameter int SCRATCH_N = 4
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register port from the cpu
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic i_reg_bank,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  // flag register control
  input wire logic i_flags_wr,
  input wire logic [7:0] i_flags_wdata,
  input wire logic i_irq_entry,
  input wire logic i_irq_return,
  input wire logic [7:0] i_irq_return_flags,
  output logic [7:0] o_flags,
  output logic [7:0] o_flags_push,
  output logic o_flags_push_valid,
  // stack pointer control
  input wire sps_pkg::sps_sp_op_e i_sp_op,
  input wire logic [7:0] i_sp_load,
  output logic [7:0] o_stack_pointer_reg,
  // memory access request
  input wire logic i_acc_valid,
  input wire logic i_acc_regspace,
  input wire sps_pkg::sps_acc_e i_acc_kind,
  input wire logic [sps_pkg::OFS_W-1:0] i_acc_offset,
  output logic o_sram_valid,
  output logic [sps_pkg::ADDR_W-1:0] o_sram_addr,
  output logic o_reg_space_valid,
  output logic [sps_pkg::OFS_W-1:0] o_reg_space_addr
);
  import sps_pkg::*;

  initial begin
    if (SCRATCH_N != 4) begin
      $error("scratch register count must be 4");
    end
  end

  logic [PAGE_W-1:0] current_page;
  logic [PAGE_W-1:0] stack_page;
  logic [PAGE_W-1:0] index_page;
  logic [PAGE_W-1:0] move_read_page;
  logic [PAGE_W-1:0] move_write_page;
  logic [7:0] flags;
  logic [7:0] stack_pointer;
  logic [7:0] scratch [SCRATCH_N];

  function automatic logic [7:0] pad_page(input logic [PAGE_W-1:0] p);
    pad_page = {{(8 - PAGE_W){1'b0}}, p};
  endfunction : pad_page

  // pages live in the low bits, reserved upper bits read zero
  wire logic sel_cur = i_reg_addr == REG_CURRENT_PAGE;
  wire logic sel_stk = i_reg_addr == REG_STACK_PAGE;
  wire logic sel_idx = i_reg_addr == REG_INDEX_PAGE;
  wire logic sel_mvr = i_reg_addr == REG_MOVE_READ_PAGE;
  wire logic sel_mvw = i_reg_addr == REG_MOVE_WRITE_PAGE;
  // paging registers sit in bank 0 only
  wire logic bank0 = !i_reg_bank;
  // scratch decode ignores the bank bit
  wire logic sel_scr = (i_reg_addr & REG_SCRATCH_MASK) == REG_SCRATCH_BASE;
  wire logic [1:0] scr_idx = i_reg_addr[1:0];
  wire logic pg_hit = bank0 && (sel_cur || sel_stk || sel_idx || sel_mvr || sel_mvw);
  wire logic any_hit = pg_hit || sel_scr;

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (sel_scr) begin
      next_rdata = scratch[scr_idx];
    end else if (bank0 && sel_cur) begin
      next_rdata = pad_page(current_page);
    end else if (bank0 && sel_stk) begin
      next_rdata = pad_page(stack_page);
    end else if (bank0 && sel_idx) begin
      next_rdata = pad_page(index_page);
    end else if (bank0 && sel_mvr) begin
      next_rdata = pad_page(move_read_page);
    end else if (bank0 && sel_mvw) begin
      next_rdata = pad_page(move_write_page);
    end
  end

  // page pointer registers; reserved bits are dropped on write (software writes zero)
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      current_page <= PAGE_RESET;
      stack_page <= PAGE_RESET;
      index_page <= PAGE_RESET;
      move_read_page <= PAGE_RESET;
      move_write_page <= PAGE_RESET;
    end else if (i_reg_wr && bank0) begin
      if (sel_cur) begin
        current_page <= i_reg_wdata[PAGE_W-1:0];
      end
      if (sel_stk) begin
        stack_page <= i_reg_wdata[PAGE_W-1:0];
      end
      if (sel_idx) begin
        index_page <= i_reg_wdata[PAGE_W-1:0];
      end
      if (sel_mvr) begin
        move_read_page <= i_reg_wdata[PAGE_W-1:0];
      end
      if (sel_mvw) begin
        move_write_page <= i_reg_wdata[PAGE_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < SCRATCH_N; k++) begin
        scratch[k] <= SCRATCH_RESET;
      end
    end else if (i_reg_wr && sel_scr) begin
      scratch[scr_idx] <= i_reg_wdata;
    end
  end

  // flags: entry saves then clears, return restores; entry wins over a plain write
  logic [7:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (i_irq_entry) begin
      next_flags = FLAGS_RESET;
    end else if (i_irq_return) begin
      next_flags = i_irq_return_flags;
    end else if (i_flags_wr) begin
      next_flags = i_flags_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags <= FLAGS_RESET;
      o_flags_push <= FLAGS_RESET;
      o_flags_push_valid <= 1'b0;
    end else begin
      flags <= next_flags;
      o_flags_push <= flags;
      o_flags_push_valid <= i_irq_entry;
    end
  end

  // stack pointer stays 8 bits, so it wraps inside its page
  logic [7:0] next_sp;
  always_comb begin
    case (i_sp_op)
      SPS_SP_HOLD: next_sp = stack_pointer;
      SPS_SP_INC: next_sp = stack_pointer + 8'h01;
      SPS_SP_DEC: next_sp = stack_pointer - 8'h01;
      SPS_SP_LOAD: next_sp = i_sp_load;
      default: next_sp = stack_pointer;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stack_pointer <= SP_RESET;
    end else begin
      stack_pointer <= next_sp;
    end
  end

  // a same-cycle stack page write is forwarded so the next stack access sees it
  wire logic stk_wr_now = i_reg_wr && bank0 && sel_stk;
  wire logic [PAGE_W-1:0] eff_stack_page = stk_wr_now ? i_reg_wdata[PAGE_W-1:0] : stack_page;

  wire logic [PAGE_W-1:0] sel_page;
  sps_page_mux u_mux (
    .i_page_mode(flags[MODE_HI:MODE_LO]),
    .i_kind(i_acc_kind),
    .i_current_page(current_page),
    .i_stack_page(eff_stack_page),
    .i_index_page(index_page),
    .i_move_read_page(move_read_page),
    .i_move_write_page(move_write_page),
    .o_page(sel_page)
  );

  // register space accesses bypass paging entirely
  wire logic to_regs = i_acc_valid && i_acc_regspace;
  wire logic to_sram = i_acc_valid && !i_acc_regspace;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sram_valid <= 1'b0;
      o_sram_addr <= '0;
      o_reg_space_valid <= 1'b0;
      o_reg_space_addr <= '0;
      o_reg_rdata <= 8'h00;
      o_reg_hit <= 1'b0;
    end else begin
      o_sram_valid <= to_sram;
      if (to_sram) begin
        o_sram_addr <= {sel_page, i_acc_offset};
      end
      o_reg_space_valid <= to_regs;
      if (to_regs) begin
        o_reg_space_addr <= i_acc_offset;
      end
      o_reg_rdata <= i_reg_rd ? next_rdata : 8'h00;
      o_reg_hit <= (i_reg_rd || i_reg_wr) && any_hit;
    end
  end

  assign o_flags = flags;
  assign o_stack_pointer_reg = stack_pointer;
endmodule : sps_sram_page_select
`default_nettype wire

// >>> rtl/sps_pkg.sv
// Purpose: constants for the sram page select block
// Assumes: 8-bit register port, 3-bit page numbers, 256-byte pages
// Notes: Function
// Function
// - Normal accesses use current page when mode is 10b or 11b, else page 0.
// - Mode 00b sends every indexed access to page 0.
// - Mode 01b sends indexed accesses to stack page; normal stays page 0.
// - Mode 10b sends indexed accesses to index page; otherwise index page unused.
// - Mode 11b sends indexed accesses to the stack page.
// - Reset clears page mode to 00b, single-page behaviour.
// - Interrupt entry pushes flags then clears them, forcing mode 00b.
// - Interrupt return restores the pushed flags including page mode.
// - Indexed register-space accesses are never paged.
// - Current page holds 3 bits; never affects stack or indexed accesses.
// - Move-indirect pointer byte uses the normal-access page: current page in modes 10b/11b, else page 0.
// - Stack accesses always use stack page; stack page resets to 00h.
// - A stack page write affects the very next stack operation.
// - Move-indirect read data comes from move read page low bits.
// - Move-indirect write data goes to move write page low bits.
// - Move-indirect page pointers work regardless of page mode.
// - Four 8-bit scratch registers, user defined only.
// - Scratch registers reachable from either register bank.
// - Stack pointer wraps FFh/00h within its page, no carry to page.
package sps_pkg;
  localparam int PAGE_W = 3;
  localparam int OFS_W = 8;
  localparam int ADDR_W = PAGE_W + OFS_W;
  localparam logic [7:0] REG_CURRENT_PAGE = 8'hd0;
  localparam logic [7:0] REG_STACK_PAGE = 8'hd1;
  localparam logic [7:0] REG_INDEX_PAGE = 8'hd3;
  localparam logic [7:0] REG_MOVE_READ_PAGE = 8'hd4;
  localparam logic [7:0] REG_MOVE_WRITE_PAGE = 8'hd5;
  localparam logic [7:0] REG_SCRATCH_BASE = 8'h60;
  localparam logic [7:0] REG_SCRATCH_MASK = 8'hfc;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0;
  localparam logic [PAGE_W-1:0] PAGE_ZERO = 3'h0;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  typedef enum logic [2:0] {
    SPS_ACC_NORMAL,
    SPS_ACC_INDEXED,
    SPS_ACC_STACK,
    SPS_ACC_MVI_PTR,
    SPS_ACC_MVI_READ,
    SPS_ACC_MVI_WRITE
  } sps_acc_e;
  typedef enum logic [1:0] {
    SPS_SP_HOLD,
    SPS_SP_INC,
    SPS_SP_DEC,
    SPS_SP_LOAD
  } sps_sp_op_e;
endpackage : sps_pkg

// >>> rtl/sps_page_mux.sv
// Purpose: combinational choice of the sram page for one access
// Assumes: all inputs settle within the cycle
// Notes: no state
`timescale 1ns/1ps
`default_nettype none
module sps_page_mux (
  input wire logic [1:0] i_page_mode,
  input wire sps_pkg::sps_acc_e i_kind,
  input wire logic [sps_pkg::PAGE_W-1:0] i_current_page,
  input wire logic [sps_pkg::PAGE_W-1:0] i_stack_page,
  input wire logic [sps_pkg::PAGE_W-1:0] i_index_page,
  input wire logic [sps_pkg::PAGE_W-1:0] i_move_read_page,
  input wire logic [sps_pkg::PAGE_W-1:0] i_move_write_page,
  output logic [sps_pkg::PAGE_W-1:0] o_page
);
  import sps_pkg::*;
  wire logic [PAGE_W-1:0] normal_page;
  logic [PAGE_W-1:0] indexed_page;
  // upper mode bit alone enables the current page
  assign normal_page = i_page_mode[1] ? i_current_page : PAGE_ZERO;
  always_comb begin
    case (i_page_mode)
      2'b00: indexed_page = PAGE_ZERO;
      2'b01: indexed_page = i_stack_page;
      2'b10: indexed_page = i_index_page;
      2'b11: indexed_page = i_stack_page;
      default: indexed_page = PAGE_ZERO;
    endcase
  end
  always_comb begin
    case (i_kind)
      SPS_ACC_NORMAL: o_page = normal_page;
      SPS_ACC_INDEXED: o_page = indexed_page;
      SPS_ACC_STACK: o_page = i_stack_page;
      SPS_ACC_MVI_PTR: o_page = normal_page;
      SPS_ACC_MVI_READ: o_page = i_move_read_page;
      SPS_ACC_MVI_WRITE: o_page = i_move_write_page;
      default: o_page = PAGE_ZERO;
    endcase
  end
endmodule : sps_page_mux
`default_nettype wire

// >>> tb/sps_sram_model.sv
// Purpose: sram array stand-in that records each paged address
// Assumes: one access per valid pulse
// Notes: no data kept; the bench only needs the address seen
`timescale 1ns/1ps
`default_nettype none
module sps_sram_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [10:0] i_addr,
  output logic [10:0] o_last
);
  initial o_last = 11'h7ff;
  always @(posedge i_clk) begin
    if (i_valid) begin
      o_last <= i_addr;
    end
  end
endmodule : sps_sram_model
`default_nettype wire

// >>> tb/sps_sram_page_select_monitor.sv
// Purpose: port-level checks for the sram page select block
// Assumes: single clock, async active-low reset
// Notes: per-mode page choice is judged by the bench
`timescale 1ns/1ps
`default_nettype none
module sps_monitor (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_flags_wr,
  input wire logic i_irq_entry,
  input wire logic i_irq_return,
  input wire logic [7:0] o_flags,
  input wire logic o_flags_push_valid,
  input wire sps_pkg::sps_sp_op_e i_sp_op,
  input wire logic [7:0] o_stack_pointer_reg,
  input wire logic i_acc_valid,
  input wire logic i_acc_regspace,
  input wire sps_pkg::sps_acc_e i_acc_kind,
  input wire logic [7:0] i_acc_offset,
  input wire logic o_sram_valid,
  input wire logic [10:0] o_sram_addr,
  input wire logic o_reg_space_valid,
  input wire logic [7:0] o_reg_space_addr
);
  import sps_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // a flag change in the access cycle makes the mode ambiguous, so skip those
  wire quiet = !i_flags_wr && !i_irq_entry && !i_irq_return;
  property p_addr; i_acc_valid && !i_acc_regspace |=> o_sram_valid && o_sram_addr[7:0] == $past(i_acc_offset); endproperty
  a_addr: assert property (p_addr) else $error("sram offset wrong");
  property p_regsp; i_acc_valid && i_acc_regspace |=> o_reg_space_valid && !o_sram_valid && o_reg_space_addr == $past(i_acc_offset); endproperty
  a_regsp: assert property (p_regsp) else $error("register space access paged");
  property p_idle; !i_acc_valid |=> !o_sram_valid && !o_reg_space_valid; endproperty
  a_idle: assert property (p_idle) else $error("access without request");
  property p_entry; i_irq_entry |=> o_flags == 8'h00 && o_flags_push_valid; endproperty
  a_entry: assert property (p_entry) else $error("entry did not clear flags");
  property p_nopush; !i_irq_entry |=> !o_flags_push_valid; endproperty
  a_nopush: assert property (p_nopush) else $error("push without entry");
  property p_page0; i_acc_valid && !i_acc_regspace && quiet && o_flags[7:6] == 2'b00 && i_acc_kind inside {SPS_ACC_NORMAL, SPS_ACC_INDEXED} |=> o_sram_addr[10:8] == 3'h0; endproperty
  a_page0: assert property (p_page0) else $error("mode 00 left page 0");
  property p_spinc; i_sp_op == SPS_SP_INC |=> o_stack_pointer_reg == $past(o_stack_pointer_reg) + 8'h01; endproperty
  a_spinc: assert property (p_spinc) else $error("stack pointer increment wrong");
  property p_sphold; i_sp_op == SPS_SP_HOLD |=> $stable(o_stack_pointer_reg); endproperty
  a_sphold: assert property (p_sphold) else $error("stack pointer moved on hold");
endmodule : sps_monitor
bind sps_sram_page_select sps_monitor i_sps_monitor (.*);
`default_nettype wire

// >>> tb/test_sps_sram_page_select.sv
// Purpose: self-checking bench for the sram page select block
// Assumes: inputs change at falling edges
// Notes: pointers set through the register port, pages seen at the sram model
`timescale 1ns/1ps
`default_nettype none
module test_sps_sram_page_select;
  import sps_pkg::*;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_reg_bank = 1'b0;
  logic i_flags_wr = 1'b0, i_irq_entry = 1'b0, i_irq_return = 1'b0, i_acc_valid = 1'b0, i_acc_regspace = 1'b0;
  logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, i_flags_wdata = '0, i_irq_return_flags = '0, i_sp_load = '0;
  logic [7:0] i_acc_offset = '0, o_reg_rdata, o_flags, o_flags_push, o_stack_pointer_reg, o_reg_space_addr;
  sps_sp_op_e i_sp_op = SPS_SP_HOLD;
  sps_acc_e i_acc_kind = SPS_ACC_NORMAL;
  logic o_reg_hit, o_flags_push_valid, o_sram_valid, o_reg_space_valid;
  logic [10:0] o_sram_addr, m_last;
  int fails = 0, check_count = 0, cyc = 0;
  always #12.5 i_clk = ~i_clk;
  sps_sram_page_select i_sps_sram_page_select (.*);
  sps_sram_model i_sps_sram_model (.i_clk, .i_valid(o_sram_valid), .i_addr(o_sram_addr), .o_last(m_last));
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b);
    @(negedge i_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata, i_reg_bank} = {1'b1, a, d, b};
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic b, input logic [8:0] e);
    @(negedge i_clk);
    {i_reg_rd, i_reg_addr, i_reg_bank} = {1'b1, a, b};
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("read", {2'b00, e}, {2'b00, o_reg_hit, o_reg_rdata});
  endtask : rd
  task automatic acc(input sps_acc_e k, input logic [7:0] ofs, input logic [2:0] pg);
    @(negedge i_clk);
    i_acc_valid = 1'b1;
    i_acc_kind = k;
    i_acc_offset = ofs;
    @(negedge i_clk);
    i_acc_valid = 1'b0;
    @(negedge i_clk);
    chk("sram addr", {pg, ofs}, m_last);
  endtask : acc
  task automatic setf(input logic [7:0] f);
    @(negedge i_clk);
    {i_flags_wr, i_flags_wdata} = {1'b1, f};
    @(negedge i_clk);
    i_flags_wr = 1'b0;
  endtask : setf
  task automatic t_modes;
    logic [2:0] ip [4] = '{3'h0, 3'h3, 3'h6, 3'h3};
    chk("flags", 11'h000, {3'h0, o_flags});
    rd(8'hd0, 1'b0, 9'h100);
    rd(8'hd1, 1'b0, 9'h100);
    rd(8'hd3, 1'b0, 9'h100);
    rd(8'hd4, 1'b0, 9'h100);
    rd(8'hd5, 1'b0, 9'h100);
    wr(8'hd0, 8'h05, 1'b0);
    wr(8'hd1, 8'h03, 1'b0);
    wr(8'hd3, 8'h06, 1'b0);
    wr(8'hd4, 8'h02, 1'b0);
    wr(8'hd5, 8'h07, 1'b0);
    for (int m = 0; m < 4; m++) begin
      setf({m[1:0], 6'h00});
      acc(SPS_ACC_NORMAL, {6'h04, m[1:0]}, m[1] ? 3'h5 : 3'h0);
      acc(SPS_ACC_INDEXED, {6'h08, m[1:0]}, ip[m]);
      acc(SPS_ACC_STACK, {6'h0c, m[1:0]}, 3'h3);
      acc(SPS_ACC_MVI_PTR, {6'h10, m[1:0]}, m[1] ? 3'h5 : 3'h0);
      acc(SPS_ACC_MVI_READ, {6'h14, m[1:0]}, 3'h2);
      acc(SPS_ACC_MVI_WRITE, {6'h18, m[1:0]}, 3'h7);
    end
  endtask : t_modes
  task automatic t_regs;
    wr(8'hd1, 8'h06, 1'b0);
    rd(8'hd1, 1'b0, 9'h106);
    rd(8'hd2, 1'b0, 9'h000);
    rd(8'hd0, 1'b1, 9'h000);
    for (int s = 0; s < 4; s++) wr({6'h18, s[1:0]}, {6'h28, s[1:0]}, 1'b1);
    for (int s = 0; s < 4; s++) rd({6'h18, s[1:0]}, 1'b0, {1'b1, 6'h28, s[1:0]});
  endtask : t_regs
  task automatic t_irq;
    setf(8'h80);
    @(negedge i_clk);
    i_irq_entry = 1'b1;
    @(negedge i_clk);
    i_irq_entry = 1'b0;
    chk("push", 11'h180, {2'b00, o_flags_push_valid, o_flags_push});
    acc(SPS_ACC_INDEXED, 8'h44, 3'h0);
    // the routine borrows the index page and must put it back itself
    wr(8'hd3, 8'h01, 1'b0);
    wr(8'hd3, 8'h06, 1'b0);
    setf(8'hc0);
    @(negedge i_clk);
    {i_irq_return, i_irq_return_flags} = {1'b1, 8'h80};
    @(negedge i_clk);
    i_irq_return = 1'b0;
    chk("flags", 11'h080, {3'h0, o_flags});
    acc(SPS_ACC_INDEXED, 8'h45, 3'h6);
    acc(SPS_ACC_STACK, 8'h46, 3'h6);
  endtask : t_irq
  task automatic t_sp_fwd;
    @(negedge i_clk);
    i_sp_op = SPS_SP_LOAD;
    i_sp_load = 8'hff;
    @(negedge i_clk);
    i_sp_op = SPS_SP_INC;
    @(negedge i_clk);
    i_sp_op = SPS_SP_DEC;
    chk("sp", 11'h000, {3'h0, o_stack_pointer_reg});
    @(negedge i_clk);
    i_sp_op = SPS_SP_HOLD;
    chk("sp", 11'h0ff, {3'h0, o_stack_pointer_reg});
    @(negedge i_clk);
    {i_reg_wr, i_reg_addr, i_reg_wdata, i_reg_bank} = {1'b1, 8'hd1, 8'h02, 1'b0};
    i_acc_valid = 1'b1;
    i_acc_kind = SPS_ACC_STACK;
    i_acc_offset = 8'h55;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    i_acc_regspace = 1'b1;
    i_acc_kind = SPS_ACC_INDEXED;
    i_acc_offset = 8'h77;
    @(negedge i_clk);
    {i_acc_valid, i_acc_regspace} = 2'b00;
    chk("stack fwd", {3'h2, 8'h55}, m_last);
    chk("regspace", 11'h177, {2'b00, o_reg_space_valid, o_reg_space_addr});
  endtask : t_sp_fwd
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // ceiling is well above the roughly 160 cycles the scenarios need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    t_modes();
    t_regs();
    t_irq();
    t_sp_fwd();
    give_verdict();
  end
endmodule : test_sps_sram_page_select
`default_nettype wire
